// ===== hdl/wsw_pkg.sv
// Package with register map, field layout and modes of the watchdog block
package wsw_pkg;

	// Register byte addresses on the Wishbone bus
	localparam logic [3:0] ADR_CTRL   = 4'h0;
	localparam logic [3:0] ADR_STATUS = 4'h4;
	localparam logic [3:0] ADR_WAKE   = 4'h8;
	localparam logic [3:0] ADR_SMODE  = 4'hc;
	localparam logic [3:0] ADR_CMD    = 4'h0;
	localparam logic [3:0] ADR_CMDREG = 4'h0;
	localparam int         ADR_MSB    = 4;
	localparam logic [4:0] ADR_INSTR  = 5'h10;

	// Watchdog control register layout and power-on value
	localparam int         CTRL_KEEP  = 7;
	localparam int         CTRL_WS_HI = 6;
	localparam int         CTRL_WS_LO = 4;
	localparam int         CTRL_EN_HI = 3;
	localparam int         CTRL_EN_LO = 0;
	localparam logic [7:0] CTRL_RST   = 8'h7a;
	localparam logic [3:0] EN_OFF     = 4'ha;

	// Status register layout
	localparam int STAT_PDF  = 0;
	localparam int STAT_TO   = 1;
	localparam int STAT_ON   = 2;
	localparam int STAT_MODE = 4;

	// Instruction register bits, one bit per instruction; every set bit of a write acts
	localparam int CMD_STOP   = 0;
	localparam int CMD_SINGLE = 1;
	localparam int CMD_FIRST  = 2;
	localparam int CMD_SECOND = 3;

	// Counter size and timeout base exponent
	localparam int         CNT_W   = 15;
	localparam int         WS_BASE = 8;
	localparam logic [1:0] DIV_MAX = 2'h3;   // System clock divided by 4

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_IDLE0,
		MODE_CLOCK_RUNNING_IDLE
	} wsw_mode_e;

	typedef enum logic [1:0] {
		LAST_NONE,
		LAST_FIRST,
		LAST_SECOND
	} wsw_last_e;

	// Terminal count for a timeout code: 2**(8+code)-1, so a wrap every 2**(8+code) ticks
	function automatic logic [CNT_W-1:0] wsw_limit(input logic [2:0] ws);
		logic [CNT_W:0] full;
		full = 16'h0001 << (WS_BASE + int'(ws));
		wsw_limit = full[CNT_W-1:0] - 15'h0001;
	endfunction

endpackage

// ===== hdl/wsw_wdt_count.sv
// Watchdog counter with selectable overflow point
`timescale 1ns/1ns
module wsw_wdt_count
(
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// Control
	input  wire logic                      tick_i,
	input  wire logic                      clr_i,
	input  wire logic [2:0]                ws_i,
	// Status
	output logic [wsw_pkg::CNT_W-1:0]      cnt_o,
	output logic                           ovf_o
);

	logic [wsw_pkg::CNT_W-1:0] cnt_q;
	logic [wsw_pkg::CNT_W-1:0] cnt_d;
	logic                      ovf_q;
	logic                      ovf_d;

	// Count ticks, wrap at the selected terminal count
	always_comb
	begin
		cnt_d = cnt_q;
		ovf_d = 1'b0;
		if (clr_i)
			cnt_d = '0;
		else if (tick_i)
		begin
			if (cnt_q >= wsw_pkg::wsw_limit(ws_i))
			begin
				cnt_d = '0;
				ovf_d = 1'b1;
			end
			else
				cnt_d = cnt_q + 15'h0001;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q <= '0;
			ovf_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
		end
	end

	assign cnt_o = cnt_q;
	assign ovf_o = ovf_q;

endmodule // wsw_wdt_count

// ===== hdl/wsw_pa_wake.sv
// Port A falling edge wake detector, one enable per pin
`timescale 1ns/1ns
module wsw_pa_wake
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Pins and enables
	input  wire logic [7:0] pin_i,
	input  wire logic [7:0] en_i,
	// Wake request
	output logic            wake_o
);

	logic [7:0] prev_q;
	logic [7:0] prev_d;
	logic [7:0] fall;
	logic       wake_q;
	logic       wake_d;

	// Per pin edge detection
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_pin
			assign prev_d[g] = pin_i[g];
			assign fall[g]   = prev_q[g] & ~pin_i[g] & en_i[g];
		end
	endgenerate

	always_comb
	begin
		wake_d = |fall;
	end

	// Pins idle high after reset so no false edge appears
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			prev_q <= 8'hff;
			wake_q <= 1'b0;
		end
		else
		begin
			prev_q <= prev_d;
			wake_q <= wake_d;
		end
	end

	assign wake_o = wake_q;

endmodule // wsw_pa_wake

// ===== hdl/wsw_top.sv
// Watchdog timer with standby and wake-up control, Wishbone slave
// How it works
// - Stop enters clock-running idle only with idle select and keep-clock set
// - Clock-running idle keeps system, time base and slow clocks on
// - Entering standby changes no stored register or port value
// - Stop clears the counter; enabled watchdog keeps counting the slow clock, the system clock source only in clock-running idle
// - Stop sets the power-down flag and clears the expired flag
// - Standby wakes on external reset, Port A edge, interrupt or overflow
// - External reset wake gives full reset; overflow wake resets PC and SP only
// - Overflow in standby sets expired flag, resets only PC and SP
// - Power-down flag cleared by power-up or clears, set by stop
// - Each Port A pin wake enabled alone; wake resumes after stop
// - Disabled or stack-full interrupt wake resumes; request stays pending
// - Enabled interrupt with free stack gets normal response after wake
// - Interrupt already requested before standby cannot wake the device
// - Option picks slow auxiliary clock or system clock over four
// - Timeout select gives 2**(8+code) watchdog clocks
// - Disabled only when option says disable and enable field is 1010
// - Control register resets to 0x7a
// - Watchdog instructions do nothing while the watchdog is disabled
// - Overflow resets the device; software clears in time to prevent it
// - Bit 7 keeps system clock running in idle
// - Two-clear option: clears must alternate, repeats have no effect
// - Counter cleared by low reset pin and by stop
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
module wsw_top
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Configuration options
	input  wire logic        cfg_src_sys_i,
	input  wire logic        cfg_wdt_off_i,
	input  wire logic        cfg_two_clear_i,
	// Clocks, pins and interrupt state
	input  wire logic        slow_tick_i,
	input  wire logic        ext_rst_n_i,
	input  wire logic [7:0]  porta_i,
	input  wire logic        irq_req_i,
	input  wire logic        irq_en_i,
	input  wire logic        stack_full_i,
	// System controls
	output logic             standby_o,
	output logic             sysclk_run_o,
	output logic             aux_clk_run_o,
	output logic             wake_o,
	output logic             wdt_reset_o,
	output logic             pc_sp_reset_o,
	output logic             sys_reset_o,
	output logic             irq_service_o,
	output logic             resume_next_o
);

	// Register state
	logic [7:0]              ctrl_q, ctrl_d;
	logic [7:0]              wake_en_q, wake_en_d;
	logic                    idle_sel_q, idle_sel_d;
	logic                    pdf_q, pdf_d;
	logic                    to_q, to_d;
	logic                    irq_pre_q, irq_pre_d;
	logic                    irq_pend_q, irq_pend_d;
	wsw_pkg::wsw_mode_e      mode_q, mode_d;
	wsw_pkg::wsw_last_e      last_q, last_d;
	logic [1:0]              div_q, div_d;
	logic                    ack_q, ack_d;
	logic [31:0]             dat_q, dat_d;
	// Registered outputs
	logic sysclk_q, sysclk_d, aux_q, aux_d, wake_q, wake_d;
	logic wreset_q, wreset_d, pcsp_q, pcsp_d, sreset_q, sreset_d;
	logic isvc_q, isvc_d, resume_q, resume_d, stby_q, stby_d;
	// Decoded terms
	logic                    req, wr, standby, wdt_on;
	logic                    stop_go, clear_ok, cnt_clr, tick, count_ok;
	logic                    is_single, is_first, is_second;
	logic                    pa_wake, ovf, irq_wake;
	logic [wsw_pkg::CNT_W-1:0] cnt;

	// Bus decode; instructions are ignored while halted
	assign req       = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr        = req & wb_we_i & wb_sel_i[0];
	assign standby   = (mode_q != wsw_pkg::MODE_RUN);
	assign stop_go   = wr & ~standby & (wb_adr_i == wsw_pkg::ADR_INSTR)
	                   & wb_dat_i[wsw_pkg::CMD_STOP];
	assign is_single = wr & ~standby & (wb_adr_i == wsw_pkg::ADR_INSTR)
	                   & wb_dat_i[wsw_pkg::CMD_SINGLE];
	assign is_first  = wr & ~standby & (wb_adr_i == wsw_pkg::ADR_INSTR)
	                   & wb_dat_i[wsw_pkg::CMD_FIRST];
	assign is_second = wr & ~standby & (wb_adr_i == wsw_pkg::ADR_INSTR)
	                   & wb_dat_i[wsw_pkg::CMD_SECOND];

	// Enable decode: both the option and the field must say off
	assign wdt_on = ~(cfg_wdt_off_i &
	                  (ctrl_q[wsw_pkg::CTRL_EN_HI:wsw_pkg::CTRL_EN_LO]
	                   == wsw_pkg::EN_OFF));

	// Clears only act when enabled; two-clear style must alternate
	always_comb
	begin
		clear_ok = 1'b0;
		if (wdt_on)
		begin
			if (!cfg_two_clear_i)
				clear_ok = is_single;
			else
				clear_ok = (is_first & (last_q != wsw_pkg::LAST_FIRST))
				         | (is_second & (last_q != wsw_pkg::LAST_SECOND));
		end
	end

	// Counter clear sources; a disabled watchdog is held at zero
	assign cnt_clr = stop_go | clear_ok | ~ext_rst_n_i | ~wdt_on;

	// System clock source stops in sleep and plain idle, slow one does not
	assign count_ok = wdt_on & (~cfg_src_sys_i |
	                  (mode_q == wsw_pkg::MODE_RUN) |
	                  (mode_q == wsw_pkg::MODE_CLOCK_RUNNING_IDLE));
	assign tick = count_ok & (cfg_src_sys_i ? (div_q == wsw_pkg::DIV_MAX)
	                                        : slow_tick_i);

	// Divide-by-four enable for the system clock source
	always_comb
	begin
		div_d = div_q + 2'h1;
	end

	wsw_wdt_count u_count
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tick_i(tick),
		.clr_i (cnt_clr),
		.ws_i  (ctrl_q[wsw_pkg::CTRL_WS_HI:wsw_pkg::CTRL_WS_LO]),
		.cnt_o (cnt),
		.ovf_o (ovf)
	);

	wsw_pa_wake u_pa
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pin_i (porta_i),
		.en_i  (wake_en_q),
		.wake_o(pa_wake)
	);

	// A request already raised at stop time cannot wake
	assign irq_wake = irq_req_i & ~irq_pre_q;

	// Register, mode and flag next state
	always_comb
	begin
		ctrl_d     = ctrl_q;
		wake_en_d  = wake_en_q;
		idle_sel_d = idle_sel_q;
		pdf_d      = pdf_q;
		to_d       = to_q;
		irq_pre_d  = irq_pre_q;
		irq_pend_d = irq_pend_q;
		mode_d     = mode_q;
		last_d     = last_q;
		wake_d     = 1'b0;
		wreset_d   = 1'b0;
		pcsp_d     = 1'b0;
		isvc_d     = 1'b0;
		resume_d   = 1'b0;
		sreset_d   = ~ext_rst_n_i;
		// Software writes to the plain registers
		if (wr && wb_adr_i == {1'b0, wsw_pkg::ADR_CTRL})
			ctrl_d = wb_dat_i[7:0];
		if (wr && wb_adr_i == {1'b0, wsw_pkg::ADR_WAKE})
			wake_en_d = wb_dat_i[7:0];
		if (wr && wb_adr_i == {1'b0, wsw_pkg::ADR_SMODE})
			idle_sel_d = wb_dat_i[0];
		// Clear instructions drop the power-down flag
		if (clear_ok)
		begin
			pdf_d = 1'b0;
			if (is_first)
				last_d = wsw_pkg::LAST_FIRST;
			else if (is_second)
				last_d = wsw_pkg::LAST_SECOND;
		end
		// Stop: flags, request snapshot and mode change, everything else holds
		if (stop_go)
		begin
			pdf_d     = 1'b1;
			to_d      = 1'b0;
			irq_pre_d = irq_req_i;
			if (!idle_sel_q)
				mode_d = wsw_pkg::MODE_SLEEP;
			else if (ctrl_q[wsw_pkg::CTRL_KEEP])
				mode_d = wsw_pkg::MODE_CLOCK_RUNNING_IDLE;
			else
				mode_d = wsw_pkg::MODE_IDLE0;
		end
		// Wake sources in priority order
		if (standby)
		begin
			if (!ext_rst_n_i)
			begin
				wake_d = 1'b1;
				mode_d = wsw_pkg::MODE_RUN;
			end
			else if (ovf)
			begin
				wake_d = 1'b1;
				to_d   = 1'b1;
				pcsp_d = 1'b1;
				mode_d = wsw_pkg::MODE_RUN;
			end
			else if (pa_wake)
			begin
				wake_d   = 1'b1;
				resume_d = 1'b1;
				mode_d   = wsw_pkg::MODE_RUN;
			end
			else if (irq_wake)
			begin
				wake_d = 1'b1;
				mode_d = wsw_pkg::MODE_RUN;
				if (irq_en_i && !stack_full_i)
					isvc_d = 1'b1;
				else
				begin
					resume_d   = 1'b1;
					irq_pend_d = 1'b1;
				end
			end
		end
		else
		begin
			// Running overflow resets the device
			if (ovf)
			begin
				to_d     = 1'b1;
				wreset_d = 1'b1;
			end
			// Deferred interrupt once enabled with stack room
			if (irq_pend_q && irq_en_i && !stack_full_i)
			begin
				isvc_d     = 1'b1;
				irq_pend_d = 1'b0;
			end
		end
		// Clocks per mode
		sysclk_d = (mode_d == wsw_pkg::MODE_RUN) ||
		           (mode_d == wsw_pkg::MODE_CLOCK_RUNNING_IDLE);
		aux_d    = (mode_d != wsw_pkg::MODE_SLEEP) || wdt_on;
		stby_d   = (mode_d != wsw_pkg::MODE_RUN);
	end

	// Bus answer: one-cycle ack, unmapped reads return zero
	always_comb
	begin
		ack_d = req;
		dat_d = 32'h0000_0000;
		if (req && !wb_we_i)
		begin
			case (wb_adr_i)
				{1'b0, wsw_pkg::ADR_CTRL}:   dat_d[7:0] = ctrl_q;
				{1'b0, wsw_pkg::ADR_STATUS}:
				begin
					dat_d[wsw_pkg::STAT_PDF] = pdf_q;
					dat_d[wsw_pkg::STAT_TO]  = to_q;
					dat_d[wsw_pkg::STAT_ON]  = wdt_on;
					dat_d[wsw_pkg::STAT_MODE +: 2] = mode_q;
				end
				{1'b0, wsw_pkg::ADR_WAKE}:   dat_d[7:0] = wake_en_q;
				{1'b0, wsw_pkg::ADR_SMODE}:  dat_d[0]   = idle_sel_q;
				default:                     dat_d      = 32'h0000_0000;
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q     <= wsw_pkg::CTRL_RST;
			wake_en_q  <= 8'h00;
			idle_sel_q <= 1'b0;
			pdf_q      <= 1'b0;
			to_q       <= 1'b0;
			irq_pre_q  <= 1'b0;
			irq_pend_q <= 1'b0;
			mode_q     <= wsw_pkg::MODE_RUN;
			last_q     <= wsw_pkg::LAST_NONE;
			div_q      <= 2'h0;
			ack_q      <= 1'b0;
			dat_q      <= 32'h0000_0000;
			sysclk_q   <= 1'b1;
			aux_q      <= 1'b1;
			wake_q     <= 1'b0;
			wreset_q   <= 1'b0;
			pcsp_q     <= 1'b0;
			sreset_q   <= 1'b0;
			isvc_q     <= 1'b0;
			resume_q   <= 1'b0;
			stby_q     <= 1'b0;
		end
		else
		begin
			ctrl_q     <= ctrl_d;
			wake_en_q  <= wake_en_d;
			idle_sel_q <= idle_sel_d;
			pdf_q      <= pdf_d;
			to_q       <= to_d;
			irq_pre_q  <= irq_pre_d;
			irq_pend_q <= irq_pend_d;
			mode_q     <= mode_d;
			last_q     <= last_d;
			div_q      <= div_d;
			ack_q      <= ack_d;
			dat_q      <= dat_d;
			sysclk_q   <= sysclk_d;
			aux_q      <= aux_d;
			wake_q     <= wake_d;
			wreset_q   <= wreset_d;
			pcsp_q     <= pcsp_d;
			sreset_q   <= sreset_d;
			isvc_q     <= isvc_d;
			resume_q   <= resume_d;
			stby_q     <= stby_d;
		end
	end

	// Outputs straight from flops
	assign wb_ack_o      = ack_q;
	assign wb_dat_o      = dat_q;
	assign standby_o     = stby_q;
	assign sysclk_run_o  = sysclk_q;
	assign aux_clk_run_o = aux_q;
	assign wake_o        = wake_q;
	assign wdt_reset_o   = wreset_q;
	assign pc_sp_reset_o = pcsp_q;
	assign sys_reset_o   = sreset_q;
	assign irq_service_o = isvc_q;
	assign resume_next_o = resume_q;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_stop_keep;
		stop_go && idle_sel_q && ctrl_q[wsw_pkg::CTRL_KEEP];
	endsequence
	sequence s_ovf_asleep;
		ovf && standby && ext_rst_n_i;
	endsequence

	a_clock_running_idle_entry: assert property (s_stop_keep |=>
		mode_q == wsw_pkg::MODE_CLOCK_RUNNING_IDLE ##1 sysclk_run_o)
		else $error("clock-running idle not entered");
	a_stop_flags: assert property (stop_go |=>
		pdf_q && !to_q && cnt == '0)
		else $error("stop did not set flags or clear counter");
	a_off_held: assert property (!wdt_on |=> cnt == '0)
		else $error("disabled watchdog counted");
	a_ovf_sleep: assert property (s_ovf_asleep |=>
		pc_sp_reset_o && to_q && !standby && !wdt_reset_o)
		else $error("standby overflow handled wrong");
	a_ovf_run: assert property (ovf && !standby |=>
		wdt_reset_o && to_q)
		else $error("running overflow gave no reset");
	a_porta_resume: assert property (pa_wake && standby &&
		ext_rst_n_i && !ovf |=> resume_next_o && wake_o)
		else $error("port wake did not resume");
	a_reset_value: assert property ($past(rst_i) |->
		ctrl_q == wsw_pkg::CTRL_RST)
		else $error("control reset value wrong");
	a_repeat_first: assert property (is_first && cfg_two_clear_i &&
		last_q == wsw_pkg::LAST_FIRST |-> !clear_ok)
		else $error("repeated first clear acted");
	a_pin_clears: assert property (!ext_rst_n_i |=>
		cnt == '0 && sys_reset_o)
		else $error("reset pin did not clear counter");

endmodule // wsw_top

// ===== sim/test_wsw_top.sv
// Self-checking bench for the watchdog and standby wake-up block
`timescale 1ns/1ns
module test_wsw_top;
	// Bus addresses widened to the bus address width
	localparam logic [4:0] A_CTRL = {1'b0, wsw_pkg::ADR_CTRL};
	localparam logic [4:0] A_STAT = {1'b0, wsw_pkg::ADR_STATUS};
	localparam logic [4:0] A_WAKE = {1'b0, wsw_pkg::ADR_WAKE};
	localparam logic [4:0] A_SYSTEM_MODE_REG = {1'b0, wsw_pkg::ADR_SMODE};
	localparam int         LIMIT  = 20000;

	// Block inputs, all given a value at time zero
	logic        clk_i           = 1'b0;
	logic        rst_i           = 1'b1;
	logic        wb_cyc_i        = 1'b0;
	logic        wb_stb_i        = 1'b0;
	logic        wb_we_i         = 1'b0;
	logic [4:0]  wb_adr_i        = 5'h00;
	logic [3:0]  wb_sel_i        = 4'hf;
	logic [31:0] wb_dat_i        = 32'h0;
	logic        cfg_src_sys_i   = 1'b0;
	logic        cfg_wdt_off_i   = 1'b0;
	logic        cfg_two_clear_i = 1'b0;
	logic        slow_tick_i     = 1'b0;
	logic        ext_rst_n_i     = 1'b1;
	logic [7:0]  porta_i         = 8'hff;
	logic        irq_req_i       = 1'b0;
	logic        irq_en_i        = 1'b0;
	logic        stack_full_i    = 1'b0;
	// Block outputs
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        standby_o;
	logic        sysclk_run_o;
	logic        aux_clk_run_o;
	logic        wake_o;
	logic        wdt_reset_o;
	logic        pc_sp_reset_o;
	logic        sys_reset_o;
	logic        irq_service_o;
	logic        resume_next_o;
	// Bench bookkeeping
	int          n_errors = 0;
	int          compares = 0;
	int          cyc_cnt  = 0;

	wsw_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .cfg_src_sys_i(cfg_src_sys_i),
		.cfg_wdt_off_i(cfg_wdt_off_i), .cfg_two_clear_i(cfg_two_clear_i),
		.slow_tick_i(slow_tick_i), .ext_rst_n_i(ext_rst_n_i),
		.porta_i(porta_i), .irq_req_i(irq_req_i), .irq_en_i(irq_en_i),
		.stack_full_i(stack_full_i), .standby_o(standby_o),
		.sysclk_run_o(sysclk_run_o), .aux_clk_run_o(aux_clk_run_o),
		.wake_o(wake_o), .wdt_reset_o(wdt_reset_o),
		.pc_sp_reset_o(pc_sp_reset_o), .sys_reset_o(sys_reset_o),
		.irq_service_o(irq_service_o), .resume_next_o(resume_next_o));

	// 10 MHz clock
	always #50 clk_i = ~clk_i;

	// Hang guard: a run past the ceiling counts as a mismatch
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == LIMIT)
		begin
			n_errors++;
			summarize();
		end
	end

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	// Classic cycle: hold the request until ack is sampled high at an edge
	task automatic wb(input logic we, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic instr(input int b);
		wr(wsw_pkg::ADR_INSTR, 32'h1 << b);
	endtask

	// Expected status word from mode, enable, expired and power-down
	function automatic logic [31:0] st(input logic [1:0] m, input logic en,
		input logic to, input logic power_down_flag);
		st = 32'h0;
		st[wsw_pkg::STAT_MODE +: 2] = m;
		st[wsw_pkg::STAT_ON]        = en;
		st[wsw_pkg::STAT_TO]        = to;
		st[wsw_pkg::STAT_PDF]       = power_down_flag;
	endfunction

	function automatic logic outsel(input int k);
		case (k)
			0:       outsel = wake_o;
			1:       outsel = wdt_reset_o;
			2:       outsel = pc_sp_reset_o;
			3:       outsel = irq_service_o;
			4:       outsel = resume_next_o;
			default: outsel = sys_reset_o;
		endcase
	endfunction

	// Cycles until the chosen output is seen high, or lim if never
	task automatic waitfor(input int k, input int lim, output int n);
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (outsel(k) !== 1'b1 && n < lim);
	endtask

	task automatic t_reset();
		rdc(A_CTRL, 32'h7a);
		rdc(A_STAT, st(2'h0, 1'b1, 1'b0, 1'b0));
		rdc(5'h14, 32'h0);
	endtask

	// Every option and field combination of the disable decision
	task automatic t_enable();
		for (int i = 0; i < 4; i++)
		begin
			cfg_wdt_off_i <= i[1];
			wr(A_CTRL, i[0] ? 32'h7a : 32'h75);
			rdc(A_STAT, st(2'h0, !(i[1] && i[0]), 1'b0, 1'b0));
		end
		cfg_wdt_off_i <= 1'b0;
	endtask

	task automatic t_clock_running_idle();
		int n;
		wr(A_SYSTEM_MODE_REG, 32'h1);
		wr(A_CTRL, 32'hf5);
		wr(A_WAKE, 32'h1);
		instr(wsw_pkg::CMD_STOP);
		chk1(sysclk_run_o & aux_clk_run_o, 1'b1);
		rdc(A_STAT, st(2'h3, 1'b1, 1'b0, 1'b1));
		porta_i <= 8'hfd;
		waitfor(0, 8, n);
		chk1(standby_o, 1'b1);
		porta_i <= 8'hfc;
		waitfor(4, 5, n);
		chk1(n < 5, 1'b1);
		porta_i <= 8'hff;
		rdc(A_STAT, st(2'h0, 1'b1, 1'b0, 1'b1));
	endtask

	task automatic t_irq();
		int n;
		wr(A_CTRL, 32'h75);
		instr(wsw_pkg::CMD_STOP);
		chk1(sysclk_run_o, 1'b0);
		irq_en_i  <= 1'b1;
		irq_req_i <= 1'b1;
		waitfor(3, 5, n);
		chk1(n < 5, 1'b1);
		chk1(wake_o, 1'b1);
		irq_req_i <= 1'b0;
		irq_en_i  <= 1'b0;
		wr(A_SYSTEM_MODE_REG, 32'h0);
		instr(wsw_pkg::CMD_STOP);
		irq_req_i <= 1'b1;
		waitfor(4, 5, n);
		chk1(n < 5, 1'b1);
		irq_en_i     <= 1'b1;
		stack_full_i <= 1'b1;
		waitfor(3, 6, n);
		chk1(n < 6, 1'b0);
		stack_full_i <= 1'b0;
		waitfor(3, 5, n);
		chk1(n < 5, 1'b1);
		irq_req_i <= 1'b0;
		irq_en_i  <= 1'b0;
	endtask

	// A request already up at stop must not wake; the reset pin must
	task automatic t_pending();
		int n;
		// Let an edge pass so the request is not driven twice in one step
		@(posedge clk_i);
		irq_req_i <= 1'b1;
		instr(wsw_pkg::CMD_STOP);
		waitfor(0, 20, n);
		chk1(n < 20, 1'b0);
		ext_rst_n_i <= 1'b0;
		waitfor(5, 5, n);
		chk1(n < 5, 1'b1);
		ext_rst_n_i <= 1'b1;
		irq_req_i   <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk1(standby_o, 1'b0);
	endtask

	task automatic t_disabled();
		cfg_wdt_off_i <= 1'b1;
		wr(A_CTRL, 32'h7a);
		wr(A_WAKE, 32'h1);
		instr(wsw_pkg::CMD_STOP);
		chk1(aux_clk_run_o, 1'b0);
		porta_i <= 8'hfe;
		repeat (4) @(posedge clk_i);
		porta_i <= 8'hff;
		instr(wsw_pkg::CMD_SINGLE);
		rdc(A_STAT, st(2'h0, 1'b0, 1'b0, 1'b1));
		cfg_wdt_off_i <= 1'b0;
		instr(wsw_pkg::CMD_SINGLE);
		rdc(A_STAT, st(2'h0, 1'b1, 1'b0, 1'b0));
	endtask

	// Timeout length for codes 0 and 1 on the slow clock and code 0 on the system clock
	task automatic t_overflow();
		int n;
		int e;
		for (int i = 0; i < 3; i++)
		begin
			cfg_src_sys_i <= (i == 2);
			wr(A_CTRL, (i == 1) ? 32'h15 : 32'h05);
			instr(wsw_pkg::CMD_SINGLE);
			slow_tick_i <= (i != 2);
			e = (i == 0) ? 256 : ((i == 1) ? 512 : 1024);
			waitfor(1, e + 16, n);
			chk1(n >= e - 8 && n <= e + 8, 1'b1);
			slow_tick_i <= 1'b0;
			rdc(A_STAT, st(2'h0, 1'b1, 1'b1, 1'b0));
		end
		cfg_src_sys_i <= 1'b0;
	endtask

	// A repeated first clear leaves the count running on
	task automatic t_two_clear();
		int n;
		cfg_two_clear_i <= 1'b1;
		instr(wsw_pkg::CMD_FIRST);
		slow_tick_i <= 1'b1;
		repeat (150) @(posedge clk_i);
		instr(wsw_pkg::CMD_FIRST);
		waitfor(1, 200, n);
		chk1(n < 128, 1'b1);
		instr(wsw_pkg::CMD_SECOND);
		waitfor(1, 200, n);
		chk1(n < 200, 1'b0);
		slow_tick_i     <= 1'b0;
		cfg_two_clear_i <= 1'b0;
	endtask

	// Stop clears a part-run count; overflow in idle resets PC and SP only
	task automatic t_standby_ovf();
		int n;
		wr(A_SYSTEM_MODE_REG, 32'h1);
		wr(A_CTRL, 32'h85);
		instr(wsw_pkg::CMD_SINGLE);
		slow_tick_i <= 1'b1;
		repeat (200) @(posedge clk_i);
		instr(wsw_pkg::CMD_STOP);
		waitfor(2, 300, n);
		chk1(n >= 248 && n <= 264, 1'b1);
		slow_tick_i <= 1'b0;
		rdc(A_STAT, st(2'h0, 1'b1, 1'b1, 1'b1));
	endtask

	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_enable();
		t_clock_running_idle();
		t_irq();
		t_pending();
		t_disabled();
		t_overflow();
		t_two_clear();
		t_standby_ovf();
		summarize();
	end
endmodule // test_wsw_top
